/* common/seq_exec_consts.svh */
// constants for the sequence execution semantics block
`ifndef SEQ_EXEC_CONSTS_SVH
`define SEQ_EXEC_CONSTS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_LATEST_STEP 4'h2
`define ADDR_FIRST_STEP 4'h3
`define ADDR_OUT_IMAGE 4'h4
`define ADDR_OPERAND 4'h5
`define ADDR_RESULT 4'h6
`define ADDR_COMMAND 4'h7
`define ADDR_POINT 4'h8
`define POINT_VAL_BIT 8
`define CTRL_RUN_BIT 0
`define CTRL_RESTORE_BIT 1
`define CTRL_HALT_ON_ERR_BIT 2
`define ST_LIVE_BIT 0
`define ST_STICKY_BIT 1
`define ST_RUN_BIT 2
`define ST_HALTED_BIT 3
`define ST_EXEC_BIT 4
`define ST_FIRST_SCAN_BIT 5
`define CMD_ERR_BIT 0
`define CMD_PREV_BIT 1
`define CMD_COND_BIT 2
`define CMD_CLASS_LSB 4
`define CMD_CLASS_MSB 6
`define CMD_GROUPS_LSB 8
`define CMD_GROUPS_MSB 9
`define CMD_STEP_LSB 16
`define CMD_STEP_MSB 31
`define CMD_SCAN_END_BIT 3
`define CTRL_RESET 3'h0
`define SIGN_MASK 16'h8000
`define GROUP_BITS 4
`endif

/* common/seq_exec_pkg.sv */
// types for the sequence execution semantics block
package seq_exec_pkg;
  typedef enum logic [2:0] {
    COND_NONE = 3'h0,
    COND_HIGH = 3'h1,
    COND_RISE = 3'h2,
    COND_LOW = 3'h3,
    COND_FALL = 3'h4,
    COND_EDGE_SFX = 3'h5
  } exec_class_t;
  typedef enum logic [1:0] {
    ONE_GROUP_DIGIT = 2'h0,
    TWO_GROUP_DIGIT = 2'h1,
    THREE_GROUP_DIGIT = 2'h2,
    FOUR_GROUP_DIGIT = 2'h3
  } digit_groups_t;
  typedef enum {RUN_STOPPED, RUN_PRIMING, RUN_ACTIVE} run_state_t;
endpackage

/* hdl/seq_exec.sv */
// sequence execution semantics: run/stop outputs, conditions, digit groups, error capture
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "seq_exec_consts.svh"
module seq_exec #(
  parameter int NUM_OUTPUTS = 16
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [NUM_OUTPUTS-1:0] out_points_o,
  output logic exec_pulse_o,
  output logic sign_o,
  output seq_exec_pkg::run_state_t run_state_o
);
  import seq_exec_pkg::*;
  // point index width; only the low PIDX_W bits of the index are used, higher index bits are dropped
  localparam int PIDX_W = $clog2(NUM_OUTPUTS);

  logic [2:0] ctrl_reg;
  logic live_err_reg;
  logic sticky_err_reg;
  logic [15:0] latest_step_reg;
  logic [15:0] first_step_reg;
  logic [NUM_OUTPUTS-1:0] saved_image_reg;
  logic [NUM_OUTPUTS-1:0] work_image_reg;
  logic [15:0] operand_reg;
  logic [15:0] result_reg;
  logic [15:0] dest_reg;
  logic halted_reg;
  logic exec_reg;
  logic first_scan_reg;
  logic prev_run_reg;
  run_state_t state_reg;
  logic [31:0] rdata_next;
  logic bus_hit;
  logic wr_ctrl;
  logic wr_status;
  logic wr_first;
  logic wr_image;
  logic wr_operand;
  logic wr_cmd;
  logic wr_point;
  logic [PIDX_W-1:0] point_idx;
  logic point_val;
  logic result_on;
  logic [15:0] result_val;
  logic cmd_err;
  logic cmd_prev;
  logic cmd_cond;
  logic cmd_scan_end;
  exec_class_t cmd_class;
  digit_groups_t cmd_groups;
  logic [15:0] cmd_step;
  logic exec_now;
  logic run_req;
  logic running;
  logic [15:0] group_mask;
  logic [15:0] group_value;

  // bus decode; every access answers in one cycle
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = bus_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADDR_CTRL);
  assign wr_status = bus_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ADDR_STATUS);
  assign wr_first = bus_hit && wb_we_i && (wb_adr_i == `ADDR_FIRST_STEP);
  assign wr_image = bus_hit && wb_we_i && (wb_adr_i == `ADDR_OUT_IMAGE);
  assign wr_operand = bus_hit && wb_we_i && (wb_adr_i == `ADDR_OPERAND);
  assign wr_cmd = bus_hit && wb_we_i && (wb_adr_i == `ADDR_COMMAND);
  assign wr_point = bus_hit && wb_we_i && (wb_adr_i == `ADDR_POINT);

  // instruction command fields
  assign cmd_err = wb_dat_i[`CMD_ERR_BIT];
  assign cmd_prev = wb_dat_i[`CMD_PREV_BIT];
  assign cmd_cond = wb_dat_i[`CMD_COND_BIT];
  assign cmd_scan_end = wb_dat_i[`CMD_SCAN_END_BIT];
  assign cmd_class = exec_class_t'(wb_dat_i[`CMD_CLASS_MSB:`CMD_CLASS_LSB]);
  assign cmd_groups = digit_groups_t'(wb_dat_i[`CMD_GROUPS_MSB:`CMD_GROUPS_LSB]);
  assign cmd_step = wb_dat_i[`CMD_STEP_MSB:`CMD_STEP_LSB];
  assign run_req = ctrl_reg[`CTRL_RUN_BIT];
  assign running = (state_reg != RUN_STOPPED) && !halted_reg;

  // single-point write: index in the low bits, value in one bit
  assign point_idx = wb_dat_i[PIDX_W-1:0];
  assign point_val = wb_dat_i[`POINT_VAL_BIT];

  // execution condition decode
  always_comb begin
    unique case (cmd_class)
      COND_NONE: exec_now = 1'b1;
      COND_HIGH: exec_now = cmd_cond;
      COND_RISE: exec_now = cmd_cond && !cmd_prev;
      COND_LOW: exec_now = !cmd_cond;
      COND_FALL: exec_now = !cmd_cond && cmd_prev;
      COND_EDGE_SFX: exec_now = cmd_cond && !cmd_prev;
      default: exec_now = 1'b0;
    endcase
  end

  // digit groups: point 0 is bit 0, four points per group
  always_comb begin
    unique case (cmd_groups)
      ONE_GROUP_DIGIT: group_mask = 16'h000F;
      TWO_GROUP_DIGIT: group_mask = 16'h00FF;
      THREE_GROUP_DIGIT: group_mask = 16'h0FFF;
      FOUR_GROUP_DIGIT: group_mask = 16'hFFFF;
    endcase
    group_value = operand_reg & group_mask;
  end

  // unconditional class runs every scan, but its result is off without the condition
  assign result_on = exec_now && ((cmd_class != COND_NONE) || cmd_cond);
  assign result_val = result_on ? group_value : 16'h0000;

  // run/stop sequencing with image save and restore
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= RUN_STOPPED;
      prev_run_reg <= 1'b0;
      first_scan_reg <= 1'b0;
    end else begin
      prev_run_reg <= run_req;
      unique case (state_reg)
        RUN_STOPPED: if (run_req && !prev_run_reg) begin
          state_reg <= RUN_PRIMING;
          first_scan_reg <= 1'b1;
        end
        RUN_PRIMING: state_reg <= RUN_ACTIVE; // outputs settle before any scan
        RUN_ACTIVE: begin
          if (!run_req) state_reg <= RUN_STOPPED;
          if (wr_cmd && cmd_scan_end) first_scan_reg <= 1'b0;
        end
      endcase
    end
  end

  // saved image: captured when leaving run, loadable by software only while stopped
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      saved_image_reg <= '0;
    end else if (state_reg == RUN_ACTIVE && !run_req) begin
      saved_image_reg <= work_image_reg;
    end else if (wr_image && state_reg == RUN_STOPPED) begin
      saved_image_reg <= wb_dat_i[NUM_OUTPUTS-1:0];
    end
  end

  // working output image the program updates
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      work_image_reg <= '0;
    end else if (state_reg == RUN_PRIMING) begin
      if (ctrl_reg[`CTRL_RESTORE_BIT]) work_image_reg <= saved_image_reg;
      else work_image_reg <= '0;
    end else if (wr_image && running) begin
      work_image_reg <= wb_dat_i[NUM_OUTPUTS-1:0]; // whole image from software
    end else if (wr_point && running) begin
      work_image_reg[point_idx] <= point_val;
    end
  end

  // output pins: off when stopped, held clear through a cleared first scan
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_points_o <= '0;
    end else if (!running) begin
      out_points_o <= '0;
    end else if (state_reg == RUN_PRIMING) begin
      // work image is still stale here, so drive the saved one directly
      if (ctrl_reg[`CTRL_RESTORE_BIT]) out_points_o <= saved_image_reg;
      else out_points_o <= '0;
    end else if (first_scan_reg && !ctrl_reg[`CTRL_RESTORE_BIT]) begin
      out_points_o <= '0;
    end else begin
      out_points_o <= work_image_reg;
    end
  end

  // grouped data path: source extract and masked destination merge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_reg <= '0;
      dest_reg <= '0;
      sign_o <= 1'b0;
      exec_pulse_o <= 1'b0;
      exec_reg <= 1'b0;
    end else begin
      exec_pulse_o <= wr_cmd && running && exec_now;
      if (wr_cmd) exec_reg <= running && exec_now; // blocked commands read as not run
      if (wr_cmd && running) begin
        result_reg <= result_val;
        sign_o <= result_on && (cmd_groups == FOUR_GROUP_DIGIT)
          && ((result_val & `SIGN_MASK) != 16'h0000);
        if (exec_now) dest_reg <= (dest_reg & ~group_mask) | result_val;
      end
    end
  end

  // operand register: no range check, bits above 15 dropped silently
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) operand_reg <= '0;
    else if (wr_operand) operand_reg <= wb_dat_i[15:0];
  end

  // control register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) ctrl_reg <= `CTRL_RESET;
    else if (wr_ctrl) ctrl_reg <= wb_dat_i[2:0];
  end

  // error flags; a new error beats a software clear in the same cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      live_err_reg <= 1'b0;
      sticky_err_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      if (wr_cmd && running && exec_now) live_err_reg <= cmd_err;
      if (wr_cmd && running && exec_now && cmd_err) sticky_err_reg <= 1'b1;
      else if (wr_status && !wb_dat_i[`ST_STICKY_BIT]) sticky_err_reg <= 1'b0;
      if (wr_cmd && running && exec_now && cmd_err && ctrl_reg[`CTRL_HALT_ON_ERR_BIT])
        halted_reg <= 1'b1;
      else if (state_reg == RUN_STOPPED) halted_reg <= 1'b0;
    end
  end

  // error step capture
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latest_step_reg <= '0;
      first_step_reg <= '0;
    end else begin
      if (wr_cmd && running && exec_now && cmd_err) latest_step_reg <= cmd_step;
      if (wr_cmd && running && exec_now && cmd_err && !sticky_err_reg)
        first_step_reg <= cmd_step;
      else if (wr_first && !sticky_err_reg) first_step_reg <= wb_dat_i[15:0];
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (wb_adr_i)
      `ADDR_CTRL: rdata_next[2:0] = ctrl_reg;
      `ADDR_STATUS: begin
        rdata_next[`ST_LIVE_BIT] = live_err_reg;
        rdata_next[`ST_STICKY_BIT] = sticky_err_reg;
        rdata_next[`ST_RUN_BIT] = running;
        rdata_next[`ST_HALTED_BIT] = halted_reg;
        rdata_next[`ST_EXEC_BIT] = exec_reg;
        rdata_next[`ST_FIRST_SCAN_BIT] = first_scan_reg;
      end
      `ADDR_LATEST_STEP: rdata_next[15:0] = latest_step_reg;
      `ADDR_FIRST_STEP: rdata_next[15:0] = first_step_reg;
      `ADDR_OUT_IMAGE: rdata_next[NUM_OUTPUTS-1:0] = saved_image_reg;
      `ADDR_OPERAND: rdata_next[15:0] = operand_reg;
      `ADDR_RESULT: rdata_next = {16'h0000, result_reg};
      `ADDR_COMMAND: rdata_next[15:0] = dest_reg;
      default: rdata_next = 32'h0000_0000; // unmapped reads as zero
    endcase
  end

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_hit;
      if (bus_hit && !wb_we_i) wb_dat_o <= rdata_next;
    end
  end

  assign run_state_o = state_reg;

  // four-group source keeps its sign bit
  sign_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && result_on && cmd_groups == FOUR_GROUP_DIGIT
     && ((operand_reg & `SIGN_MASK) != 16'h0000)) |=> sign_o) else $error("sign lost");
  first_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ($past(sticky_err_reg) && sticky_err_reg && !$past(wr_first))
    |-> $stable(first_step_reg)) else $error("first step moved");
  stop_off_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == RUN_STOPPED) |=> (out_points_o == '0)) else $error("outputs on");
  latest_cap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now && cmd_err) |=> (latest_step_reg == $past(cmd_step)))
    else $error("latest step");
  rise_once_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && cmd_class == COND_RISE && cmd_prev) |=> !exec_pulse_o)
    else $error("rise repeat");
  fall_once_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && cmd_class == COND_FALL && !cmd_prev) |=> !exec_pulse_o)
    else $error("fall repeat");
  save_img_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == RUN_ACTIVE && !run_req) |=> (saved_image_reg == $past(work_image_reg)))
    else $error("image not saved");
  clear_first_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (first_scan_reg && !ctrl_reg[`CTRL_RESTORE_BIT]) |=> (out_points_o == '0))
    else $error("clear scan");
  live_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now && !cmd_err) |=> !live_err_reg)
    else $error("live not cleared");

  // execution classes: the pulse runs or skips as the class decides, and an unconditional result is off without the condition
  none_exec_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && cmd_class == COND_NONE) |=> exec_pulse_o)
    else $error("unconditional skipped");
  result_off_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && cmd_class == COND_NONE && !cmd_cond) |=> (result_reg == 16'h0000))
    else $error("result not off");
  high_skip_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && cmd_class == COND_HIGH && !cmd_cond) |=> !exec_pulse_o)
    else $error("high level ran");
  rise_exec_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && cmd_class == COND_RISE && cmd_cond && !cmd_prev) |=> exec_pulse_o)
    else $error("rise missed");
  low_skip_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && cmd_class == COND_LOW && cmd_cond) |=> !exec_pulse_o)
    else $error("low level ran");
  fall_exec_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && cmd_class == COND_FALL && !cmd_cond && cmd_prev) |=> exec_pulse_o)
    else $error("fall missed");
  suffix_once_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && cmd_class == COND_EDGE_SFX && cmd_prev) |=> !exec_pulse_o)
    else $error("suffix repeat");

  // outputs, image and error capture
  point_one_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_point && running && state_reg == RUN_ACTIVE)
    |=> ($countones(work_image_reg ^ $past(work_image_reg)) <= 1)) else $error("several points");
  restore_out_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == RUN_PRIMING && ctrl_reg[`CTRL_RESTORE_BIT] && !halted_reg)
    |=> (out_points_o == $past(saved_image_reg))) else $error("image not restored");
  dest_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now) |=> ((dest_reg & ~$past(group_mask))
    == ($past(dest_reg) & ~$past(group_mask)))) else $error("uncovered point written");
  live_set_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now && cmd_err) |=> live_err_reg)
    else $error("live not set");
  sticky_set_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now && cmd_err) |=> sticky_err_reg)
    else $error("sticky not set");
  first_cap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_cmd && running && exec_now && cmd_err && !sticky_err_reg)
    |=> (first_step_reg == $past(cmd_step))) else $error("first step missed");
  halt_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (halted_reg && wr_cmd) |=> !exec_pulse_o)
    else $error("ran while halted");
  stop_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (!running) |=> !exec_pulse_o)
    else $error("ran while stopped");
endmodule

/* tb/seq_exec_tb_top.sv */
// self-checking bench for the sequence execution block
`timescale 1ns/1ps
`include "seq_exec_consts.svh"
module seq_exec_tb_top;
  import seq_exec_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [5:2] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, pulse, sgn;
  logic [15:0] outp;
  run_state_t rs;
  int bad_count = 0;
  int checked = 0;
  int pulses = 0;
  int cyc_n = 0;
  logic [31:0] seed = 32'h29;
  logic [15:0] cv [3] = '{16'h8000, 16'hFFFF, 16'h7FFF};

  always #4 mclk_i = ~mclk_i;

  seq_exec #(.NUM_OUTPUTS(16)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .out_points_o(outp), .exec_pulse_o(pulse), .sign_o(sgn), .run_state_o(rs));

  // count execution pulses; a hung run ends as a failure
  always @(posedge mclk_i) begin
    if (pulse === 1'h1) pulses++;
    cyc_n++;
    if (cyc_n == 5000) begin
      $display("[ERR] %0t run timeout", $time);
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // xorshift keeps the random stream repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] cw(logic e, logic p, logic c, logic s, logic [2:0] k,
                                     logic [1:0] g, logic [15:0] st);
    return {st, 6'h00, g, 1'h0, k, s, c, p, e};
  endfunction

  // expected execution per condition class
  function automatic logic xexec(logic [2:0] k, logic p, logic c);
    case (k)
      3'h0: return 1'h1;
      3'h1: return c;
      3'h3: return !c;
      3'h4: return p && !c;
      default: return c && !p;
    endcase
  endfunction

  function automatic logic [15:0] gm(logic [1:0] g);
    return 16'hFFFF >> (12 - 4 * g);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'h1 && n < 64);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n == 64) begin
      $display("[ERR] %0t bus timeout", $time);
      bad_count++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] exp,
                      input string m);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q & msk, exp, m);
  endtask

  initial begin
    logic [31:0] op;
    logic [15:0] img;
    logic [2:0] k;
    logic [1:0] g;
    logic v;
    int p0;
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    chk(32'(outp), 32'h0, "stopped outputs");
    rchk(`ADDR_STATUS, 32'h3F, 32'h0, "reset status");
    rchk(4'hF, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test reset done");
    // restore option: saved image shows before any scan
    op = rnd();
    wr(`ADDR_OUT_IMAGE, op);
    wr(`ADDR_CTRL, 32'h3);
    rchk(`ADDR_STATUS, 32'h4, 32'h4, "running");
    chk(32'(outp), op & 32'hFFFF, "restored");
    chk(32'(rs), 32'(RUN_ACTIVE), "active");
    op = rnd();
    wr(`ADDR_OUT_IMAGE, op);
    wr(`ADDR_CTRL, 32'h0);
    rchk(`ADDR_OUT_IMAGE, 32'hFFFF, op & 32'hFFFF, "saved on stop");
    chk(32'(outp), 32'h0, "off when stopped");
    $display("test restore done");
    // clear option: outputs held off until first scan ends
    wr(`ADDR_CTRL, 32'h1);
    rchk(`ADDR_STATUS, 32'h24, 32'h24, "first scan");
    op = rnd();
    wr(`ADDR_OUT_IMAGE, op);
    rchk(`ADDR_STATUS, 32'h20, 32'h20, "still first scan");
    chk(32'(outp), 32'h0, "cleared");
    wr(`ADDR_COMMAND, cw(1'h0, 1'h0, 1'h1, 1'h1, 3'h0, 2'h0, 16'h0));
    rchk(`ADDR_STATUS, 32'h20, 32'h0, "scan over");
    chk(32'(outp), op & 32'hFFFF, "after scan");
    // one point write moves exactly that point
    img = op[15:0];
    op = rnd();
    img[op[3:0]] = op[`POINT_VAL_BIT];
    wr(`ADDR_POINT, op);
    repeat (2) @(posedge mclk_i);
    chk(32'(outp), 32'(img), "one point");
    img[15] = 1'h1;
    wr(`ADDR_POINT, 32'h0000010F);
    repeat (2) @(posedge mclk_i);
    chk(32'(outp), 32'(img), "top point");
    $display("test clear done");
    // every class with every condition history, all group counts
    for (int i = 0; i < 24; i++) begin
      k = 3'(i / 4);
      g = 2'(i + i / 4);
      op = rnd();
      v = xexec(k, i[1], i[0]);
      p0 = pulses;
      wr(`ADDR_OPERAND, op);
      wr(`ADDR_COMMAND, cw(1'h0, i[1], i[0], 1'h0, k, g, 16'(i)));
      rchk(`ADDR_STATUS, 32'h10, {27'h0, v, 4'h0}, "exec flag");
      rchk(`ADDR_RESULT, 32'hFFFF, (v && (k != 3'h0 || i[0])) ? op & 32'(gm(g)) : 32'h0,
           "grouped value");
      chk(32'(pulses - p0), 32'(v), "exec pulse");
      if (v && g == 2'h3 && (k != 3'h0 || i[0])) chk(32'(sgn), 32'(op[15]), "sign");
    end
    foreach (cv[j]) begin
      wr(`ADDR_OPERAND, 32'(cv[j]));
      wr(`ADDR_COMMAND, cw(1'h0, 1'h0, 1'h1, 1'h0, 3'h1, 2'h3, 16'h0));
      rchk(`ADDR_RESULT, 32'hFFFF, 32'(cv[j]), "signed word");
      chk(32'(sgn), 32'(cv[j][15]), "sign bit");
    end
    $display("test classes done");
    // error flags and step capture, continue mode
    wr(`ADDR_COMMAND, cw(1'h1, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0011));
    rchk(`ADDR_STATUS, 32'hB, 32'h3, "flags set");
    rchk(`ADDR_LATEST_STEP, 32'hFFFF, 32'h0011, "latest");
    wr(`ADDR_COMMAND, cw(1'h1, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0022));
    wr(`ADDR_LATEST_STEP, 32'h0);
    rchk(`ADDR_LATEST_STEP, 32'hFFFF, 32'h0022, "latest again");
    rchk(`ADDR_FIRST_STEP, 32'hFFFF, 32'h0011, "first held");
    wr(`ADDR_COMMAND, cw(1'h0, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0));
    rchk(`ADDR_STATUS, 32'h3, 32'h2, "live cleared");
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_COMMAND, cw(1'h1, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0033));
    rchk(`ADDR_FIRST_STEP, 32'hFFFF, 32'h0033, "first recaptured");
    // halt mode blocks further execution
    wr(`ADDR_CTRL, 32'h5);
    wr(`ADDR_COMMAND, cw(1'h1, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0044));
    wr(`ADDR_COMMAND, cw(1'h0, 1'h0, 1'h1, 1'h0, 3'h1, 2'h0, 16'h0));
    rchk(`ADDR_STATUS, 32'h18, 32'h8, "halted");
    wr(`ADDR_CTRL, 32'h0);
    rchk(`ADDR_STATUS, 32'h4, 32'h0, "stopped");
    chk(32'(outp), 32'h0, "final off");
    $display("test errors done");
    complete_run();
  end
endmodule
